// file: include/lcdn_defines.vh
// Constants for the lamp current detect node.
`ifndef LCDN_DEFINES_VH
`define LCDN_DEFINES_VH
`define LCDN_SAMPLE_W 8
`define LCDN_NODE_ADDR 8'h04
`define LCDN_SENSOR_ADDR 8'h02
`define LCDN_BCAST_ADDR 8'h00
`define LCDN_CMD_OFF 8'h00
`define LCDN_CMD_ON 8'h01
`define LCDN_ACC_W 24
`define LCDN_THRESH_RESET 24'h000800
`define LCDN_DARK_RESET 8'h40
`define LCDN_LIGHT_RESET 8'h80
`define LCDN_HPF_SHIFT 4
`define LCDN_FIFO_DEPTH 16
`endif

// file: core/lcdn_fifo.v
// Synchronous FIFO for lamp current samples.
module lcdn_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire do_wr;
	wire do_rd;
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign do_wr = ce && in_valid && in_ready;
	assign do_rd = ce && out_valid && out_ready;
	always @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end
	always @(posedge clk) begin
		if (reset) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count <= count + 1'b1;
			end else if (do_rd && !do_wr) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // lcdn_fifo

// file: core/lcdn_node.v
// Lamp current detect node: filter, integrator, threshold and lamp control.
// Notes on behaviour
// RULE1: Samples are unsigned eight-bit converter codes.
// RULE2: High-pass filter removes the constant offset.
// RULE3: Rectify and integrate over one mains period.
// RULE4: Period integral above threshold means lamp on.
// RULE5: One switch output lights or extinguishes lamp.
// RULE6: Two buttons switch the lamp locally.
// RULE7: Report lamp state; obey addressed on/off commands.
// RULE8: Node answers fixed address four.
// RULE9: Broadcast on/off commands are obeyed too.
// RULE10: Light sensor traffic comes from address two.
// RULE11: Darkness switches lamp on, daylight off.
// RULE12: Controller can query each lamp's state.
// RULE13: Accumulator cleared per period; threshold loaded at reset.
`include "lcdn_defines.vh"
module lcdn_node #(
	parameter SW = `LCDN_SAMPLE_W,
	parameter AW = `LCDN_ACC_W,
	parameter FIFO_DEPTH = `LCDN_FIFO_DEPTH,
	parameter [AW-1:0] THRESH_INIT = `LCDN_THRESH_RESET
) (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire [SW-1:0] current_sense_in,
	input wire sample_valid,
	output reg sample_ready,
	input wire period_start,
	input wire button_on,
	input wire button_off,
	input wire [7:0] msg_addr,
	input wire [7:0] msg_data,
	input wire msg_valid,
	input wire query,
	output reg lamp_switch_out,
	output reg lamp_lit,
	output reg [AW-1:0] period_integral,
	output reg period_done,
	output reg report_valid,
	output reg [7:0] report_data
);
	// ----------------------------------------------------------------
	// Sample buffer
	// ----------------------------------------------------------------
	wire fifo_in_ready;
	wire [SW-1:0] fifo_data;
	wire fifo_valid;
	wire take;
	lcdn_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.in_data(current_sense_in),
		.in_valid(sample_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(take)
	);
	// The filter drains one sample per cycle; a pending period end stalls it.
	assign take = !period_start;
	// ----------------------------------------------------------------
	// High-pass filter and rectifier
	// ----------------------------------------------------------------
	// The DC estimate is a leaky average with extra fraction bits, so the
	// offset settles without drift at the cost of a slow start-up.
	localparam EW = SW + `LCDN_HPF_SHIFT;
	reg [EW-1:0] dc_est;
	wire [EW-1:0] sample_ext;
	wire signed [EW:0] diff_full;
	wire signed [SW:0] hp_out;
	wire [SW:0] magnitude;
	assign sample_ext = {fifo_data, {`LCDN_HPF_SHIFT{1'b0}}}; // RULE1
	assign diff_full = $signed({1'b0, sample_ext}) - $signed({1'b0, dc_est});
	assign hp_out = diff_full[EW:`LCDN_HPF_SHIFT]; // RULE2
	assign magnitude = hp_out[SW] ? (~hp_out + 1'b1) : hp_out; // RULE3
	wire [EW-1:0] dc_step;
	assign dc_step = diff_full[EW] ?
		(dc_est - (((~diff_full[EW-1:0]) + 1'b1) >> `LCDN_HPF_SHIFT)) :
		(dc_est + (diff_full[EW-1:0] >> `LCDN_HPF_SHIFT));
	always @(posedge clk) begin
		if (reset) begin
			dc_est <= {1'b1, {(EW-1){1'b0}}};
		end else if (ce && fifo_valid && take) begin
			dc_est <= dc_step; // RULE2
		end
	end
	// ----------------------------------------------------------------
	// Integrator and threshold
	// ----------------------------------------------------------------
	reg [AW-1:0] acc;
	reg [AW-1:0] threshold;
	wire [AW-1:0] next_acc;
	assign next_acc = acc + {{(AW-SW-1){1'b0}}, magnitude};
	always @(posedge clk) begin
		if (reset) begin
			acc <= {AW{1'b0}};
			threshold <= THRESH_INIT; // RULE13
			lamp_lit <= 1'b0;
			period_integral <= {AW{1'b0}};
			period_done <= 1'b0;
		end else if (ce) begin
			period_done <= 1'b0;
			if (period_start) begin
				period_integral <= acc; // RULE3
				lamp_lit <= (acc > threshold); // RULE4
				period_done <= 1'b1;
				acc <= {AW{1'b0}}; // RULE13
			end else if (fifo_valid) begin
				acc <= next_acc; // RULE3
			end
		end
	end
	// ----------------------------------------------------------------
	// Lamp control and network messages
	// ----------------------------------------------------------------
	reg [7:0] dark_level;
	reg [7:0] light_level;
	wire for_me;
	wire bcast;
	wire from_sensor;
	assign for_me = msg_valid && (msg_addr == `LCDN_NODE_ADDR); // RULE8
	assign bcast = msg_valid && (msg_addr == `LCDN_BCAST_ADDR); // RULE9
	assign from_sensor = msg_valid && (msg_addr == `LCDN_SENSOR_ADDR); // RULE10
	always @(posedge clk) begin
		if (reset) begin
			lamp_switch_out <= 1'b0;
			dark_level <= `LCDN_DARK_RESET;
			light_level <= `LCDN_LIGHT_RESET;
			sample_ready <= 1'b0;
		end else if (ce) begin
			sample_ready <= fifo_in_ready;
			// Buttons take priority over network traffic in the same cycle.
			if (button_on) begin
				lamp_switch_out <= 1'b1; // RULE6
			end else if (button_off) begin
				lamp_switch_out <= 1'b0; // RULE6
			end else if ((for_me || bcast) && msg_data == `LCDN_CMD_ON) begin
				lamp_switch_out <= 1'b1; // RULE7
			end else if ((for_me || bcast) && msg_data == `LCDN_CMD_OFF) begin
				lamp_switch_out <= 1'b0; // RULE7
			end else if (from_sensor && msg_data < dark_level) begin
				lamp_switch_out <= 1'b1; // RULE11
			end else if (from_sensor && msg_data > light_level) begin
				lamp_switch_out <= 1'b0; // RULE11
			end
		end
	end
	// Report: bit0 detected state, bit1 commanded state, so a dead lamp shows.
	always @(posedge clk) begin
		if (reset) begin
			report_valid <= 1'b0;
			report_data <= 8'h00;
		end else if (ce) begin
			report_valid <= period_done || query; // RULE7 RULE12
			report_data <= {6'h00, lamp_switch_out, lamp_lit}; // RULE12
		end
	end
endmodule // lcdn_node

// file: verif/lcdn_node_properties.sv
// Port checker for the lamp current detect node.
module lcdn_props #(
	parameter AW = 24,
	parameter [AW-1:0] THRESH_INIT = 24'h000800
) (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire button_on,
	input wire button_off,
	input wire [7:0] msg_addr,
	input wire [7:0] msg_data,
	input wire msg_valid,
	input wire query,
	input wire period_start,
	input wire lamp_switch_out,
	input wire lamp_lit,
	input wire [AW-1:0] period_integral,
	input wire period_done,
	input wire report_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Buttons outrank the network, so network checks need both buttons idle.
	wire nm = ce && msg_valid && !button_on && !button_off;
	addr_on_a: assert property (nm && msg_addr == 8'h04 && msg_data == 8'h01 |=> lamp_switch_out)
		else $error("addressed on missed");
	addr_off_a: assert property (nm && msg_addr == 8'h04 && msg_data == 8'h00 |=> !lamp_switch_out)
		else $error("addressed off missed");
	bcast_on_a: assert property (nm && msg_addr == 8'h00 && msg_data == 8'h01 |=> lamp_switch_out)
		else $error("broadcast on missed");
	foreign_addr_a: assert property (nm && msg_addr == 8'h07 |=> $stable(lamp_switch_out))
		else $error("foreign address obeyed");
	button_on_a: assert property (ce && button_on |=> lamp_switch_out)
		else $error("button on missed");
	button_off_a: assert property (ce && button_off && !button_on |=> !lamp_switch_out)
		else $error("button off missed");
	period_done_a: assert property (ce && period_start |=> period_done)
		else $error("period result missing");
	lamp_lit_a: assert property (period_done |-> lamp_lit == (period_integral > THRESH_INIT))
		else $error("lamp state wrong");
	query_rep_a: assert property (ce && query |=> report_valid)
		else $error("query unanswered");
	cover property (period_done && lamp_lit);
	cover property (report_valid);
	cover property (nm && msg_addr == 8'h02);
endmodule // lcdn_props
bind lcdn_node lcdn_props #(.AW(AW), .THRESH_INIT(THRESH_INIT)) u_props (.clk, .reset, .ce, .button_on,
	.button_off, .msg_addr, .msg_data, .msg_valid, .query, .period_start, .lamp_switch_out, .lamp_lit,
	.period_integral, .period_done, .report_valid);

// file: verif/lcdn_ctl.sv
// Network controller model: lamp messages and state queries.
module lcdn_ctl (
	input wire clk,
	output logic [7:0] msg_addr = 8'h00,
	output logic [7:0] msg_data = 8'h00,
	output logic msg_valid = 0,
	output logic query = 0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle lines show the inverse of the last value so stale data never looks valid.
	task send(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		msg_addr <= a;
		msg_data <= d;
		msg_valid <= 1;
		@(posedge clk);
		msg_valid <= 0;
		msg_addr <= ~a;
		msg_data <= ~d;
	endtask
	task ask;
		@(posedge clk);
		query <= 1;
		@(posedge clk);
		query <= 0;
	endtask
endmodule // lcdn_ctl

// file: verif/tb.sv
// Self-checking testbench for the lamp current detect node.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset = 1, ce = 1, sv = 0, ps = 0, bon = 0, boff = 0;
	logic [7:0] s = 8'h80, ma, md, rd;
	logic mv, q, lso, lit, pd, rv, srdy;
	logic [23:0] pi;
	int n_errors = 0, checked = 0, cyc = 0;
	always #20 clk = ~clk;
	lcdn_ctl ctl (.clk, .msg_addr(ma), .msg_data(md), .msg_valid(mv), .query(q));
	lcdn_node dut (.clk, .reset, .ce, .current_sense_in(s), .sample_valid(sv), .sample_ready(srdy), .period_start(ps),
		.button_on(bon), .button_off(boff), .msg_addr(ma), .msg_data(md), .msg_valid(mv), .query(q),
		.lamp_switch_out(lso), .lamp_lit(lit), .period_integral(pi), .period_done(pd), .report_valid(rv),
		.report_data(rd));
	task chk(input string n, input logic [23:0] e, input logic [23:0] v);
		checked++;
		if (v !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, v);
		end
	endtask
	task print_verdict;
		if (n_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task msg(input logic [7:0] a, input logic [7:0] d, input logic e);
		ctl.send(a, d);
		#1 chk("switch", e, lso);
	endtask
	task t_net;
		msg(8'h04, 8'h01, 1);
		msg(8'h07, 8'h00, 1);
		msg(8'h04, 8'h00, 0);
		msg(8'h00, 8'h01, 1);
		msg(8'h00, 8'h00, 0);
		msg(8'h02, 8'h10, 1);
		msg(8'h02, 8'hf0, 0);
		@(posedge clk);
		ce <= 0;
		msg(8'h04, 8'h01, 0);
		@(posedge clk);
		ce <= 1;
	endtask
	task btn(input logic on, input logic off, input logic e);
		@(posedge clk);
		bon <= on;
		boff <= off;
		@(posedge clk);
		bon <= 0;
		boff <= 0;
		#1 chk("button", e, lso);
	endtask
	task t_btn;
		btn(1, 0, 1);
		btn(0, 1, 0);
		btn(1, 1, 1);
	endtask
	// Samples swing around a mid code; a swing of one code (80/7f) must leave the integral near zero.
	task t_period(input logic [7:0] a, input logic e);
		for (int i = 0; i < 64; i++) begin
			@(posedge clk);
			sv <= 1;
			s <= i[0] ? a : ~a;
		end
		@(posedge clk);
		sv <= 0;
		repeat (4) @(posedge clk);
		ps <= 1;
		@(posedge clk);
		ps <= 0;
		#1 chk("done", 1, pd);
		chk("lit", e, lit);
		chk("integral", e, pi > 24'h000800);
	endtask
	// Holding the period boundary stalls the drain, so the buffer must fill.
	task t_full;
		@(posedge clk);
		ps <= 1;
		sv <= 1;
		s <= 8'h80;
		repeat (20) @(posedge clk);
		#1 chk("full", 0, srdy);
		@(posedge clk);
		ps <= 0;
		sv <= 0;
		repeat (20) @(posedge clk);
		#1 chk("drained", 1, srdy);
	endtask
	task t_query;
		ctl.ask();
		#1 chk("report", 1, rv);
		chk("state", 2'b10, rd[1:0]);
	endtask
	always @(posedge clk) if (++cyc == 2000) begin
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clk);
		reset <= 0;
		#1 chk("reset", 0, lso);
		t_net();
		t_btn();
		t_period(8'hff, 1);
		t_period(8'h80, 0);
		t_query();
		t_full();
		print_verdict();
	end
endmodule // tb
